// ===== design/aisr_defs.svh
/*
 Register offsets, field positions, reset values and timing figures
 of the sampling-interval and shutdown-cause register slice.
 Assumes a 10 MHz system clock.
*/
`ifndef AISR_DEFS_SVH
`define AISR_DEFS_SVH
`define AISR_OFS_CELL     8'h3e
`define AISR_OFS_AUX      8'h3f
`define AISR_OFS_TEST     8'h43
`define AISR_OFS_SHDN     8'h50
`define AISR_OFS_CTRL     8'h0c
`define AISR_OFS_PDLIM    8'h0d
`define AISR_OFS_COMMCNT  8'h29
`define AISR_RST_CELL     8'h00
`define AISR_RST_AUX      32'h0000_0000
`define AISR_RST_TEST     16'h0900
`define AISR_RST_PDLIM    24'h00_0000
`define AISR_CTRL_PD      0
`define AISR_CTRL_CLR     1
`define AISR_SH_CTRL      7
`define AISR_SH_DIGT      6
`define AISR_SH_AON       5
`define AISR_SH_ANA       4
`define AISR_SH_NPN       1
`define AISR_SH_ATHM      0
`define AISR_SH_RSVD_MASK 8'hf3
`define AISR_CLK_HZ       10000000
`define AISR_CLK_NS       100
`define AISR_TICK_HZ      4000
`define AISR_PER0_NS      4130
`define AISR_PER1_NS      5960
`define AISR_PER2_NS      8020
`define AISR_PER3_NS      10000
`define AISR_PER4_NS      12600
`define AISR_PER5_NS      14900
`define AISR_PER6_NS      17400
`define AISR_PER7_NS      19900
`define AISR_PER8_NS      24900
`define AISR_PER9_NS      30000
`define AISR_PERA_NS      40100
`define AISR_PERB_NS      60000
`define AISR_PERC_NS      100000
`define AISR_PERD_NS      200000
`define AISR_PERE_NS      500000
`define AISR_PERF_NS      1000000
`endif

// ===== design/aisr_pkg.sv
/*
 Types of the sampling-interval and shutdown-cause register slice.
 Assumes aisr_defs.svh for all figures.
*/
`default_nettype none
package aisr_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } aisr_bus_req_t;
    typedef struct packed {
        logic       start;
        logic [3:0] chan;
    } aisr_conv_req_t;
    typedef enum logic [3:0] {
        AISR_CH_CELL, AISR_CH_DIE, AISR_CH_AUX0, AISR_CH_AUX1, AISR_CH_AUX2,
        AISR_CH_AUX3, AISR_CH_AUX4, AISR_CH_AUX5, AISR_CH_AUX6, AISR_CH_AUX7,
        AISR_CH_MOD, AISR_CH_REF, AISR_CH_NEG
    } aisr_chan_t;
    typedef enum logic {AISR_IDLE, AISR_COUNT} aisr_state_t;
endpackage : aisr_pkg
`default_nettype wire

// ===== design/aisr_regs.sv
/*
 Sampling-interval registers, shared interval timer, comm power-down
 timeout and shutdown-cause status of a battery monitor.
 Assumes a plain register port on clk, cause inputs from the analog
 die and pins (asynchronous), conversion starts from the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aisr_defs.svh"
module aisr_regs
    import aisr_pkg::*;
#(
    parameter int unsigned PER_E_CYC = `AISR_PERE_NS / `AISR_CLK_NS,
    parameter int unsigned PER_F_CYC = `AISR_PERF_NS / `AISR_CLK_NS
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst_n,
    // Register port
    input  wire aisr_bus_req_t  bus_req,
    output logic [31:0]         rd_data,
    // Sequencer side
    input  wire aisr_conv_req_t conv_req,
    input  wire logic           comm_activity,
    output logic                smp_busy,
    output logic                smp_strobe,
    output logic                pd_request,
    // Shutdown cause inputs, asynchronous
    input  wire logic           digital_thermal_in,
    input  wire logic           io_supply_low_in,
    input  wire logic           aon_por_in,
    input  wire logic           analog_request_in,
    input  wire logic           regulator_timeout_in,
    input  wire logic           analog_thermal_in
);
    localparam int unsigned TICK_DIV = `AISR_CLK_HZ / `AISR_TICK_HZ;

    logic [7:0]  cell_r;
    logic [31:0] aux_r;
    logic [15:0] test_r;
    logic [23:0] pdlim_r;
    logic [23:0] comm_cnt_r;
    logic [11:0] div_r;
    logic        tick_r;
    logic [7:0]  shdn_r;
    logic [5:0]  s1_r, s2_r, s3_r, lvl_r;
    logic        timeout_r;
    aisr_state_t state_r;
    logic [13:0] cnt_r;
    logic [3:0]  code_r;

    wire logic ctrl_wr = bus_req.wr && bus_req.addr == `AISR_OFS_CTRL;
    wire logic pd_wr   = ctrl_wr && bus_req.wdata[`AISR_CTRL_PD];
    wire logic clr_wr  = ctrl_wr && bus_req.wdata[`AISR_CTRL_CLR];

    function automatic logic [13:0] period_cyc(input logic [3:0] code);
        case (code)
            4'h0: period_cyc = 14'(`AISR_PER0_NS / `AISR_CLK_NS);
            4'h1: period_cyc = 14'(`AISR_PER1_NS / `AISR_CLK_NS);
            4'h2: period_cyc = 14'(`AISR_PER2_NS / `AISR_CLK_NS);
            4'h3: period_cyc = 14'(`AISR_PER3_NS / `AISR_CLK_NS);
            4'h4: period_cyc = 14'(`AISR_PER4_NS / `AISR_CLK_NS);
            4'h5: period_cyc = 14'(`AISR_PER5_NS / `AISR_CLK_NS);
            4'h6: period_cyc = 14'(`AISR_PER6_NS / `AISR_CLK_NS);
            4'h7: period_cyc = 14'(`AISR_PER7_NS / `AISR_CLK_NS);
            4'h8: period_cyc = 14'(`AISR_PER8_NS / `AISR_CLK_NS);
            4'h9: period_cyc = 14'(`AISR_PER9_NS / `AISR_CLK_NS);
            4'ha: period_cyc = 14'(`AISR_PERA_NS / `AISR_CLK_NS);
            4'hb: period_cyc = 14'(`AISR_PERB_NS / `AISR_CLK_NS);
            4'hc: period_cyc = 14'(`AISR_PERC_NS / `AISR_CLK_NS);
            4'hd: period_cyc = 14'(`AISR_PERD_NS / `AISR_CLK_NS);
            4'he: period_cyc = 14'(PER_E_CYC);
            default: period_cyc = 14'(PER_F_CYC);
        endcase
    endfunction : period_cyc

    function automatic logic [3:0] chan_code(input logic [3:0] ch);
        case (ch)
            AISR_CH_CELL: chan_code = cell_r[7:4];
            AISR_CH_DIE:  chan_code = cell_r[3:0];
            AISR_CH_MOD:  chan_code = test_r[15:12];
            AISR_CH_REF:  chan_code = test_r[7:4];
            AISR_CH_NEG:  chan_code = test_r[3:0];
            default:      chan_code = aux_r[5'(31 - 4 * (ch - 4'h2)) -: 4];
        endcase
    endfunction : chan_code

    // Software registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cell_r  <= `AISR_RST_CELL;
            aux_r   <= `AISR_RST_AUX;
            test_r  <= `AISR_RST_TEST;
            pdlim_r <= `AISR_RST_PDLIM;
        end else if (bus_req.wr) begin
            if (bus_req.addr == `AISR_OFS_CELL) begin
                cell_r <= bus_req.wdata[7:0];
            end else if (bus_req.addr == `AISR_OFS_AUX) begin
                aux_r <= bus_req.wdata;
            end else if (bus_req.addr == `AISR_OFS_TEST) begin
                // Reserved nibble stored as written; software keeps it 1001
                test_r <= bus_req.wdata[15:0];
            end else if (bus_req.addr == `AISR_OFS_PDLIM) begin
                pdlim_r <= bus_req.wdata[23:0];
            end
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 32'h0000_0000;
        end else if (bus_req.rd) begin
            if (bus_req.addr == `AISR_OFS_CELL) begin
                rd_data <= {24'h00_0000, cell_r};
            end else if (bus_req.addr == `AISR_OFS_AUX) begin
                rd_data <= aux_r;
            end else if (bus_req.addr == `AISR_OFS_TEST) begin
                rd_data <= {16'h0000, test_r};
            end else if (bus_req.addr == `AISR_OFS_SHDN) begin
                rd_data <= {24'h00_0000, shdn_r & `AISR_SH_RSVD_MASK};
            end else if (bus_req.addr == `AISR_OFS_PDLIM) begin
                rd_data <= {8'h00, pdlim_r};
            end else if (bus_req.addr == `AISR_OFS_COMMCNT) begin
                rd_data <= {8'h00, comm_cnt_r};
            end else begin
                rd_data <= 32'h0000_0000;
            end
        end else begin
            rd_data <= 32'h0000_0000;
        end
    end

    // 4 kHz tick enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r  <= 12'h000;
            tick_r <= 1'b0;
        end else if (div_r == 12'(TICK_DIV - 1)) begin
            div_r  <= 12'h000;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + 12'h001;
            tick_r <= 1'b0;
        end
    end

    // Comm timeout counter; a zero limit disables the power-down timeout
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            comm_cnt_r <= 24'h00_0000;
            timeout_r  <= 1'b0;
        end else begin
            timeout_r <= tick_r && pdlim_r != 24'h00_0000
                         && comm_cnt_r + 24'h00_0001 == pdlim_r;
            if (bus_req.wr && bus_req.addr == `AISR_OFS_COMMCNT) begin
                comm_cnt_r <= bus_req.wdata[23:0];
            end else if (comm_activity) begin
                comm_cnt_r <= 24'h00_0000;
            end else if (tick_r) begin
                comm_cnt_r <= comm_cnt_r + 24'h00_0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_request <= 1'b0;
        end else begin
            pd_request <= pd_wr || timeout_r;
        end
    end

    // Three-stage sync; a level counts once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r  <= 6'h00;
            s2_r  <= 6'h00;
            s3_r  <= 6'h00;
            lvl_r <= 6'h00;
        end else begin
            s1_r <= {digital_thermal_in, io_supply_low_in, aon_por_in,
                     analog_request_in, regulator_timeout_in, analog_thermal_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
        end
    end

    // Sticky causes: only rst_n (power-on) or a clear write drops them; set wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shdn_r <= 8'h00;
        end else begin
            shdn_r <= (clr_wr ? 8'h00 : shdn_r) | {
                pd_request,
                lvl_r[5] | lvl_r[4],
                lvl_r[3],
                lvl_r[2],
                2'b00,
                lvl_r[1],
                lvl_r[0]};
        end
    end

    // Sampling interval timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r    <= AISR_IDLE;
            cnt_r      <= 14'h0000;
            code_r     <= 4'h0;
            smp_busy   <= 1'b0;
            smp_strobe <= 1'b0;
        end else begin
            smp_strobe <= 1'b0;
            case (state_r)
                AISR_IDLE: begin
                    if (conv_req.start) begin
                        code_r   <= chan_code(conv_req.chan);
                        cnt_r    <= period_cyc(chan_code(conv_req.chan)) - 14'h0001;
                        state_r  <= AISR_COUNT;
                        smp_busy <= 1'b1;
                    end
                end
                AISR_COUNT: begin
                    if (cnt_r == 14'h0001) begin
                        smp_strobe <= 1'b1;
                        smp_busy   <= 1'b0;
                        state_r    <= AISR_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 14'h0001;
                    end
                end
                default: state_r <= AISR_IDLE;
            endcase
        end
    end

    // Helper: cycles since the accepted start
    logic [13:0] elapsed_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            elapsed_r <= 14'h0000;
        end else if (state_r == AISR_IDLE) begin
            elapsed_r <= 14'h0000;
        end else begin
            elapsed_r <= elapsed_r + 14'h0001;
        end
    end
    wire logic acc = conv_req.start && state_r == AISR_IDLE;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_period_length: assert property (smp_strobe |->
        $past(elapsed_r) + 14'h0002 == period_cyc(code_r))
        else $error("Sample strobe off the decoded period");
    a_cell_code: assert property (acc && conv_req.chan == AISR_CH_CELL
        |=> code_r == $past(cell_r[7:4])) else $error("Cell code wrong");
    a_die_code: assert property (acc && conv_req.chan == AISR_CH_DIE
        |=> code_r == $past(cell_r[3:0])) else $error("Die code wrong");
    a_aux0_code: assert property (acc && conv_req.chan == AISR_CH_AUX0
        |=> code_r == $past(aux_r[31:28])) else $error("Aux0 code wrong");
    a_aux7_code: assert property (acc && conv_req.chan == AISR_CH_AUX7
        |=> code_r == $past(aux_r[3:0])) else $error("Aux7 code wrong");
    a_mod_code: assert property (acc && conv_req.chan == AISR_CH_MOD
        |=> code_r == $past(test_r[15:12])) else $error("Module code wrong");
    a_ref_code: assert property (acc && conv_req.chan == AISR_CH_REF
        |=> code_r == $past(test_r[7:4])) else $error("Ref code wrong");
    a_neg_code: assert property (acc && conv_req.chan == AISR_CH_NEG
        |=> code_r == $past(test_r[3:0])) else $error("Pump code wrong");
    a_pd_flag_set: assert property (pd_wr |-> ##2 shdn_r[`AISR_SH_CTRL])
        else $error("Power-down flag not set");
    a_thermal_flag: assert property (digital_thermal_in [*4] |->
        ##[1:2] shdn_r[`AISR_SH_DIGT]) else $error("Digital thermal flag missing");
    a_por_flag: assert property (aon_por_in [*4] |-> ##[1:2] shdn_r[`AISR_SH_AON])
        else $error("Supply POR flag missing");
    a_ana_flag: assert property (analog_request_in [*4] |->
        ##[1:2] shdn_r[`AISR_SH_ANA]) else $error("Analog request flag missing");
    a_rsvd_zero: assert property (bus_req.rd && bus_req.addr == `AISR_OFS_SHDN
        |=> rd_data[3:2] == 2'b00) else $error("Reserved bits not zero");
    a_npn_flag: assert property (regulator_timeout_in [*4] |->
        ##[1:2] shdn_r[`AISR_SH_NPN]) else $error("Regulator flag missing");
    a_athm_flag: assert property (analog_thermal_in [*4] |->
        ##[1:2] shdn_r[`AISR_SH_ATHM]) else $error("Analog thermal flag missing");
    a_tick_spacing: assert property (tick_r |=> !tick_r [*8])
        else $error("Tick faster than divider");
    a_flags_sticky: assert property (|($past(shdn_r) & ~shdn_r) |-> $past(clr_wr))
        else $error("Cause flag dropped without clear");

    c_strobe: cover property (acc ##[1:1000] smp_strobe);
    c_timeout: cover property (timeout_r ##1 pd_request);
    c_clear_set: cover property (clr_wr && lvl_r[0]);
endmodule : aisr_regs
`default_nettype wire

// ===== verification/aisr_regs_tb.sv
/*
 Self-checking testbench of the sampling-interval and shutdown-cause slice.
 Assumes aisr_regs with shortened codes E and F, and a 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aisr_defs.svh"
module aisr_regs_tb import aisr_pkg::*;;
    logic           clk;
    logic           rst_n;
    aisr_bus_req_t  bus_req;
    logic [31:0]    rd_data;
    aisr_conv_req_t conv_req;
    logic           comm_activity;
    logic           smp_busy;
    logic           smp_strobe;
    logic           pd_request;
    logic [5:0]     causes;
    int             num_errors;
    int             checks;
    // Codes E and F shortened to 200 and 300 cycles
    localparam int PER_TAB [16] = '{41, 59, 80, 100, 126, 149, 174, 199,
                                    249, 300, 401, 600, 1000, 2000, 200, 300};
    localparam int CAUSE_BIT [6] = '{6, 6, 5, 4, 1, 0};

    aisr_regs #(.PER_E_CYC(200), .PER_F_CYC(300)) i_aisr_regs (
        .clk                  (clk),
        .rst_n                (rst_n),
        .bus_req              (bus_req),
        .rd_data              (rd_data),
        .conv_req             (conv_req),
        .comm_activity        (comm_activity),
        .smp_busy             (smp_busy),
        .smp_strobe           (smp_strobe),
        .pd_request           (pd_request),
        .digital_thermal_in   (causes[0]),
        .io_supply_low_in     (causes[1]),
        .aon_por_in           (causes[2]),
        .analog_request_in    (causes[3]),
        .regulator_timeout_in (causes[4]),
        .analog_thermal_in    (causes[5])
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic print_verdict();
        $display("Checks %0d, errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        check(rd_data, exp);
    endtask : rd_check

    // Counts from the edge that takes the start to the strobe
    task automatic measure(input logic [3:0] ch, input int exp);
        int n;
        n = 0;
        @(posedge clk);
        conv_req <= '{start: 1'b1, chan: ch};
        @(posedge clk);
        conv_req.start <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (n == 1) check(smp_busy, 1'b1);
        end while (smp_strobe !== 1'b1 && n < 20000);
        // Strobe seen just after edge P-1 is the one sampled at edge P
        check(n + 1, exp);
        check(smp_busy, 1'b0);
    endtask : measure

    // Called at an edge; looks once per cycle, the current one first
    task automatic pd_pulses(input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            #1;
            if (pd_request === 1'b1) n++;
            @(posedge clk);
        end
    endtask : pd_pulses

    task automatic test_access();
        rd_check(`AISR_OFS_CELL, 32'h0);
        rd_check(`AISR_OFS_TEST, 32'h0000_0900);
        rd_check(`AISR_OFS_SHDN, 32'h0);
        wr_reg(`AISR_OFS_CELL, 32'hffff_ff2b);
        wr_reg(`AISR_OFS_AUX, 32'h4321_0765);
        wr_reg(`AISR_OFS_TEST, 32'h0000_7968);
        wr_reg(`AISR_OFS_SHDN, 32'h0000_00ff);
        wr_reg(8'h20, 32'hffff_ffff);
        rd_check(`AISR_OFS_CELL, 32'h0000_002b);
        rd_check(`AISR_OFS_AUX, 32'h4321_0765);
        rd_check(`AISR_OFS_TEST, 32'h0000_7968);
        rd_check(`AISR_OFS_SHDN, 32'h0);
        rd_check(8'h20, 32'h0);
    endtask : test_access

    task automatic test_periods();
        logic [31:0] aux;
        aux = 32'h4321_0765;
        measure(4'(AISR_CH_CELL), PER_TAB[2]);
        measure(4'(AISR_CH_MOD), PER_TAB[7]);
        measure(4'(AISR_CH_REF), PER_TAB[6]);
        measure(4'(AISR_CH_NEG), PER_TAB[8]);
        for (int i = 0; i < 8; i++) begin
            measure(4'(2 + i), PER_TAB[(aux >> (28 - 4 * i)) & 32'hf]);
        end
        for (int k = 0; k < 16; k++) begin
            wr_reg(`AISR_OFS_CELL, {24'h0, 4'h2, 4'(k)});
            measure(4'(AISR_CH_DIE), PER_TAB[k]);
        end
    endtask : test_periods

    // Flags must outlive their inputs until the clear write
    task automatic test_causes();
        int n;
        wr_reg(`AISR_OFS_CTRL, 32'h1);
        pd_pulses(5, n);
        check(n, 1);
        rd_check(`AISR_OFS_SHDN, 32'h80);
        wr_reg(`AISR_OFS_CTRL, 32'h2);
        rd_check(`AISR_OFS_SHDN, 32'h0);
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            causes <= 6'(1 << i);
            repeat (8) @(posedge clk);
            causes <= 6'h0;
            repeat (8) @(posedge clk);
            rd_check(`AISR_OFS_SHDN, 32'h1 << CAUSE_BIT[i]);
            wr_reg(`AISR_OFS_CTRL, 32'h2);
            rd_check(`AISR_OFS_SHDN, 32'h0);
        end
        // Clear while the causes still stand: set wins
        @(posedge clk);
        causes <= 6'h38;
        repeat (8) @(posedge clk);
        wr_reg(`AISR_OFS_CTRL, 32'h2);
        rd_check(`AISR_OFS_SHDN, 32'h13);
        @(posedge clk);
        causes <= 6'h0;
        repeat (8) @(posedge clk);
        wr_reg(`AISR_OFS_CTRL, 32'h2);
        rd_check(`AISR_OFS_SHDN, 32'h0);
    endtask : test_causes

    task automatic test_timeout();
        int n;
        int polls;
        polls = 0;
        wr_reg(`AISR_OFS_COMMCNT, 32'h0);
        // Poll up to the first tick so the later timing is known to within two cycles
        do begin
            @(posedge clk);
            bus_req <= '{addr: `AISR_OFS_COMMCNT, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
            @(posedge clk);
            bus_req.rd <= 1'b0;
            #1;
            polls++;
        end while (rd_data !== 32'h1 && polls < 2000);
        check(rd_data, 32'h1);
        wr_reg(`AISR_OFS_COMMCNT, 32'h5);
        rd_check(`AISR_OFS_COMMCNT, 32'h5);
        @(posedge clk);
        comm_activity <= 1'b1;
        @(posedge clk);
        comm_activity <= 1'b0;
        rd_check(`AISR_OFS_COMMCNT, 32'h0);
        wr_reg(`AISR_OFS_PDLIM, 32'h2);
        // Limit hit two ticks after the clear, about 4990 cycles from here
        pd_pulses(4980, n);
        check(n, 0);
        pd_pulses(40, n);
        check(n, 1);
        wr_reg(`AISR_OFS_PDLIM, 32'h0);
        rd_check(`AISR_OFS_SHDN, 32'h80);
    endtask : test_timeout

    initial begin
        num_errors = 0;
        checks = 0;
        rst_n = 1'b0;
        bus_req = '0;
        conv_req = '0;
        comm_activity = 1'b0;
        causes = 6'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        test_access();
        test_periods();
        test_causes();
        test_timeout();
        print_verdict();
    end

    // Whole run needs about 15000 cycles
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
endmodule : aisr_regs_tb
`default_nettype wire
